// file: pkg/hmr_defs.svh
// Constants for the host MAC address, hash and PHY management register bank.
// Assumes a 250 MHz register clock and a 32-bit AXI4-Lite register bus.
`ifndef HMR_DEFS_SVH
`define HMR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define HMR_IDX_ADDR_HIGH      6'h02
`define HMR_IDX_ADDR_LOW       6'h03
`define HMR_IDX_HASH_HIGH      6'h04
`define HMR_IDX_HASH_LOW       6'h05
`define HMR_IDX_MGMT_ACCESS    6'h06
`define HMR_IDX_MGMT_DATA      6'h07
`define HMR_IDX_HOST_CONTROL   6'h0A

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HMR_ACC_PHY_MSB        15
`define HMR_ACC_PHY_LSB        11
`define HMR_ACC_IDX_MSB        10
`define HMR_ACC_IDX_LSB        6
`define HMR_ACC_WNR_BIT        1
`define HMR_ACC_BUSY_BIT       0
`define HMR_CTL_PASS_ALL_BIT   0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define HMR_RST_ADDR_HIGH      16'hFFFF
`define HMR_RST_ADDR_LOW       32'h0FFFFFFF
`define HMR_RST_HASH           32'h00000000
`define HMR_RST_MGMT_DATA      16'h0000

// ----------------------------------------------------------------------------
// Serial loader byte addresses
// ----------------------------------------------------------------------------
`define HMR_EE_ADDR_LOW_B0     8'h01
`define HMR_EE_ADDR_LOW_B3     8'h04
`define HMR_EE_ADDR_HIGH_B0    8'h05
`define HMR_EE_ADDR_HIGH_B1    8'h06

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HMR_CLK_PERIOD_NS      4
`define HMR_MDC_MIN_PERIOD_NS  400
`define HMR_MDC_HALF_CYC       ((`HMR_MDC_MIN_PERIOD_NS / 2 + `HMR_CLK_PERIOD_NS - 1) / `HMR_CLK_PERIOD_NS)
`define HMR_MGMT_FRAME_BITS    64
`define HMR_MGMT_TA_BIT        46
`define HMR_MGMT_DATA_BIT      48
`define HMR_CRC_POLY           32'h04C11DB7
`define HMR_AXI_OKAY           2'h0
`define HMR_AXI_SLVERR         2'h2

`endif

// file: pkg/hmr_pkg.sv
// Types for the host MAC address, hash and PHY management register bank.
// Assumes the constants header is compiled alongside.
`default_nettype none
package hmr_pkg;

	// ------------------------------------------------------------------------
	// Management engine states
	// ------------------------------------------------------------------------
	typedef enum logic {MG_IDLE, MG_SHIFT} hmr_mgmt_e;

	// Byte written by the power-on serial loader.
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} hmr_ee_wr_s;

	// Destination address of a multicast frame from the fabric.
	typedef struct packed {
		logic        valid;
		logic [47:0] da;
	} hmr_mc_req_s;

	// Filter verdict for one frame.
	typedef struct packed {
		logic valid;
		logic accept;
	} hmr_mc_res_s;

	// Whole state of the register bank.
	typedef struct packed {
		logic [15:0] addr_hi;
		logic [31:0] addr_lo;
		logic [31:0] hash_hi;
		logic [31:0] hash_lo;
		logic [4:0]  target_phy_address;
		logic [4:0]  reg_idx;
		logic        wnr;
		logic        busy;
		logic [15:0] mdata;
		logic        pass_all;
		logic        aw_got;
		logic [5:0]  aw_idx;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		hmr_mgmt_e   mg;
		logic [5:0]  div;
		logic [5:0]  bitn;
		logic [63:0] shift;
		logic [15:0] rx;
		logic        mdc;
		logic        mdio_o;
		logic        mdio_oe_n;
		hmr_mc_res_s mc;
	} hmr_state_s;

endpackage
`default_nettype wire

// file: src/hmr_regs.sv
// Host MAC station address, multicast hash filter and PHY management bank.
// Assumes an AXI4-Lite master, a serial loader that writes address bytes at
// power-on, and an internal PHY reached over a clause 22 management pin pair.
//
// Operation
// - Address high holds bits 47:32, resets FFFF.
// - Loader bytes 05h,06h fill address high.
// - Address low holds 31:0, printed reset value.
// - Loader bytes 01h..04h fill address low.
// - Six-bit hash selects word and bit.
// - Hash bit one accepts, zero rejects.
// - Pass-all-multicast accepts every multicast frame.
// - Hash table high/low words, reset zero.
// - Filter judges only fabric-to-host frames.
// - Access register: PHY address, register index.
// - Direction bit: one writes, zero reads.
// - Busy bit set by software, hardware clears.
// - Data register stable during transfer.
// - Data register holds 16 bits, reset zero.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "hmr_defs.svh"

module hmr_regs
	import hmr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire hmr_ee_wr_s  ee_wr,
	input  wire hmr_mc_req_s mc_req,
	output hmr_mc_res_s      mc_res,
	output logic             mdc,
	output logic             mdio_o,
	output logic             mdio_oe_n,
	input  wire logic        mdio_i
);

	// ------------------------------------------------------------------------
	// State and helpers
	// ------------------------------------------------------------------------
	hmr_state_s st_r;                  // Registered state of the whole bank.
	hmr_state_s st_nxt;                // Next value of the state.
	logic [5:0] ar_idx;                // Word index of the read address.
	logic [5:0] mc_hash;               // Hash of the offered destination address.
	logic [63:0] hash_tbl;             // Both hash words side by side.

	// Merge a write into an old word, one byte lane per strobe bit.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// CRC-32 of the destination address, first transmitted bit first.
	// The hash is the six most significant bits of the running remainder.
	function automatic logic [5:0] da_hash(input logic [47:0] da);
		logic [31:0] crc;
		crc = 32'hFFFFFFFF;
		for (int i = 0; i < 48; i++)
		begin
			if (crc[31] ^ da[i])
			begin
				crc = {crc[30:0], 1'b0} ^ `HMR_CRC_POLY;
			end
			else
			begin
				crc = {crc[30:0], 1'b0};
			end
		end
		return crc[31:26];
	endfunction

	assign ar_idx   = s_axi_araddr[7:2];
	assign mc_hash  = da_hash(mc_req.da);
	assign hash_tbl = {st_r.hash_hi, st_r.hash_lo};

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	// One process computes every register so that the bus, the loader and the
	// management engine see one consistent order of priority.
	always_comb
	begin
		logic [31:0] acc_new;
		logic [31:0] data_new;
		logic        do_write;
		acc_new  = 32'h00000000;
		data_new = 32'h00000000;
		do_write = 1'b0;
		st_nxt   = st_r;

		// Write address and data are taken independently, in either order.
		if (s_axi_awvalid && st_r.awready)
		begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_idx  = s_axi_awaddr[7:2];
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready)
		begin
			st_nxt.w_got  = 1'b1;
			st_nxt.wdata  = s_axi_wdata;
			st_nxt.wstrb  = s_axi_wstrb;
			st_nxt.wready = 1'b0;
		end

		// Both halves held: perform the write and raise the response.
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
		begin
			do_write      = 1'b1;
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = `HMR_AXI_OKAY;
		end

		// Response taken: reopen both channels for the next write.
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid  = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
		end

		// Register writes; reserved bits are simply not stored.
		if (do_write)
		begin
			unique case (st_r.aw_idx)
				`HMR_IDX_ADDR_HIGH:
				begin
					st_nxt.addr_hi = 16'(merge({16'h0000, st_r.addr_hi}, st_r.wdata,
						st_r.wstrb));
				end
				`HMR_IDX_ADDR_LOW:
				begin
					st_nxt.addr_lo = merge(st_r.addr_lo, st_r.wdata, st_r.wstrb);
				end
				`HMR_IDX_HASH_HIGH:
				begin
					st_nxt.hash_hi = merge(st_r.hash_hi, st_r.wdata, st_r.wstrb);
				end
				`HMR_IDX_HASH_LOW:
				begin
					st_nxt.hash_lo = merge(st_r.hash_lo, st_r.wdata, st_r.wstrb);
				end
				`HMR_IDX_MGMT_ACCESS:
				begin
					// Writes while a transfer runs are dropped so the frame
					// in flight keeps its address and direction.
					if (!st_r.busy)
					begin
						acc_new = merge({16'h0000, st_r.target_phy_address, st_r.reg_idx, 4'h0,
							st_r.wnr, 1'b0}, st_r.wdata, st_r.wstrb);
						st_nxt.target_phy_address = acc_new[`HMR_ACC_PHY_MSB:`HMR_ACC_PHY_LSB];
						st_nxt.reg_idx  = acc_new[`HMR_ACC_IDX_MSB:`HMR_ACC_IDX_LSB];
						st_nxt.wnr      = acc_new[`HMR_ACC_WNR_BIT];
						st_nxt.busy     = acc_new[`HMR_ACC_BUSY_BIT];
					end
				end
				`HMR_IDX_MGMT_DATA:
				begin
					// Held stable for the whole transfer.
					if (!st_r.busy)
					begin
						data_new     = merge({16'h0000, st_r.mdata}, st_r.wdata, st_r.wstrb);
						st_nxt.mdata = data_new[15:0];
					end
				end
				`HMR_IDX_HOST_CONTROL:
				begin
					if (st_r.wstrb[0])
					begin
						st_nxt.pass_all = st_r.wdata[`HMR_CTL_PASS_ALL_BIT];
					end
				end
				default:
				begin
					st_nxt.bresp = `HMR_AXI_SLVERR;
				end
			endcase
		end

		// Loader bytes land after any bus write of the same cycle; software
		// is expected to stay away from the address until loading ends.
		if (ee_wr.valid)
		begin
			if (ee_wr.addr >= `HMR_EE_ADDR_LOW_B0 && ee_wr.addr <= `HMR_EE_ADDR_LOW_B3)
			begin
				st_nxt.addr_lo[(ee_wr.addr - `HMR_EE_ADDR_LOW_B0) * 8 +: 8] = ee_wr.data;
			end
			if (ee_wr.addr == `HMR_EE_ADDR_HIGH_B0)
			begin
				st_nxt.addr_hi[7:0] = ee_wr.data;
			end
			if (ee_wr.addr == `HMR_EE_ADDR_HIGH_B1)
			begin
				st_nxt.addr_hi[15:8] = ee_wr.data;
			end
		end

		// Read channel: one beat answered the cycle after the address.
		if (s_axi_arvalid && st_r.arready)
		begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid  = 1'b1;
			st_nxt.rresp   = `HMR_AXI_OKAY;
			unique case (ar_idx)
				`HMR_IDX_ADDR_HIGH:    st_nxt.rdata = {16'h0000, st_r.addr_hi};
				`HMR_IDX_ADDR_LOW:     st_nxt.rdata = st_r.addr_lo;
				`HMR_IDX_HASH_HIGH:    st_nxt.rdata = st_r.hash_hi;
				`HMR_IDX_HASH_LOW:     st_nxt.rdata = st_r.hash_lo;
				`HMR_IDX_MGMT_ACCESS:  st_nxt.rdata = {16'h0000, st_r.target_phy_address, st_r.reg_idx,
					4'h0, st_r.wnr, st_r.busy};
				`HMR_IDX_MGMT_DATA:    st_nxt.rdata = {16'h0000, st_r.mdata};
				`HMR_IDX_HOST_CONTROL: st_nxt.rdata = {31'h00000000, st_r.pass_all};
				default:
				begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rresp = `HMR_AXI_SLVERR;
				end
			endcase
		end
		if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid  = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// Multicast verdict for frames the fabric hands to the host MAC.
		st_nxt.mc.valid  = mc_req.valid;
		st_nxt.mc.accept = mc_req.valid && (st_r.pass_all || hash_tbl[mc_hash]);

		// Management engine.
		unique case (st_r.mg)
			MG_IDLE:
			begin
				// A start request written this cycle launches next cycle.
				if (st_r.busy)
				begin
					st_nxt.mg        = MG_SHIFT;
					st_nxt.div       = 6'h00;
					st_nxt.bitn      = 6'h00;
					st_nxt.mdc       = 1'b0;
					st_nxt.shift     = {32'hFFFFFFFF, 2'b01,
						st_r.wnr ? 2'b01 : 2'b10, st_r.target_phy_address, st_r.reg_idx,
						st_r.wnr ? 2'b10 : 2'b11,
						st_r.wnr ? st_r.mdata : 16'hFFFF};
					st_nxt.mdio_o    = 1'b1;
					st_nxt.mdio_oe_n = 1'b0;
				end
			end
			MG_SHIFT:
			begin
				if (st_r.div == 6'(`HMR_MDC_HALF_CYC - 1))
				begin
					st_nxt.div = 6'h00;
					st_nxt.mdc = !st_r.mdc;
					if (!st_r.mdc)
					begin
						// Rising edge: the PHY's data bits are sampled.
						if (!st_r.wnr && st_r.bitn >= 6'(`HMR_MGMT_DATA_BIT))
						begin
							st_nxt.rx = {st_r.rx[14:0], mdio_i};
						end
					end
					else if (st_r.bitn == 6'(`HMR_MGMT_FRAME_BITS - 1))
					begin
						// Last falling edge: release the pin and finish.
						st_nxt.mg        = MG_IDLE;
						st_nxt.busy      = 1'b0;
						st_nxt.mdio_oe_n = 1'b1;
						st_nxt.mdio_o    = 1'b1;
						if (!st_r.wnr)
						begin
							st_nxt.mdata = st_r.rx;
						end
					end
					else
					begin
						// Falling edge: present the next bit, or let go of
						// the pin from turnaround onward on a read.
						st_nxt.bitn      = st_r.bitn + 6'h01;
						st_nxt.shift     = {st_r.shift[62:0], 1'b0};
						st_nxt.mdio_o    = st_r.shift[62];
						st_nxt.mdio_oe_n = !st_r.wnr &&
							(st_r.bitn + 6'h01 >= 6'(`HMR_MGMT_TA_BIT));
					end
				end
				else
				begin
					st_nxt.div = st_r.div + 6'h01;
				end
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	// Synchronous reset; the clock enable freezes everything while low.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st_r           <= '0;
			st_r.addr_hi   <= `HMR_RST_ADDR_HIGH;
			st_r.addr_lo   <= `HMR_RST_ADDR_LOW;
			st_r.hash_hi   <= `HMR_RST_HASH;
			st_r.hash_lo   <= `HMR_RST_HASH;
			st_r.mdata     <= `HMR_RST_MGMT_DATA;
			st_r.awready   <= 1'b1;
			st_r.wready    <= 1'b1;
			st_r.arready   <= 1'b1;
			st_r.mg        <= MG_IDLE;
			st_r.mdio_o    <= 1'b1;
			st_r.mdio_oe_n <= 1'b1;
		end
		else if (ce)
		begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------------
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign mc_res        = st_r.mc;
	assign mdc           = st_r.mdc;
	assign mdio_o        = st_r.mdio_o;
	assign mdio_oe_n     = st_r.mdio_oe_n;

endmodule // hmr_regs
`default_nettype wire

// file: verif/hmr_phy_model.sv
// Behavioural internal PHY that answers clause 22 management frames.
// Assumes a pull-up on the data line and a management clock that stops between frames.
`timescale 1ns/1ps
`default_nettype none
module hmr_phy_model #(
	parameter logic [4:0]	PHY_AD = 5'h01
) (
	input  wire logic	mdc,
	input  wire logic	mdio_o,
	input  wire logic	mdio_oe_n,
	output logic		mdio_i
);
	logic [15:0]	regs [32];	// Register file, seeded with 1000h plus the index.
	logic [31:0]	sh = '1;	// Last bits seen on the line.
	logic [16:0]	out = '1;	// Turnaround zero followed by read data.
	logic [4:0]	ri = '0;	// Register index of the frame under way.
	logic		drv = 0;
	logic		rdop = 0;
	int		n = 0;		// Bit count since the start bit; zero between frames.
	// The pull-up wins whenever nobody drives the line.
	assign mdio_i = !mdio_oe_n ? mdio_o : drv ? out[16] : 1'b1;
	initial
		foreach (regs[i]) regs[i] = 16'h1000 + 16'(i);
	// Decode on the rising clock: a zero after 32 ones opens a frame.
	always @(posedge mdc)
	begin
		if (n == 0)
			n = (sh == '1 && !mdio_i) ? 1 : 0;
		else
			n = n + 1;
		sh = {sh[30:0], mdio_i};
		if (n == 14)
		begin
			rdop = sh[11:10] == 2'b10 && sh[9:5] == PHY_AD;
			ri = sh[4:0];
		end
		if (n == 32)
		begin
			if (sh[29:28] == 2'b01 && sh[27:23] == PHY_AD)
				regs[sh[22:18]] = sh[15:0];
			n = 0;
		end
	end
	// Data leaves on the falling clock, so it is settled when sampled.
	always @(negedge mdc)
	begin
		out = {out[15:0], 1'b1};
		if (n == 0)
			drv = 0;
		if (n == 15 && rdop)
		begin
			drv = 1;
			out = {1'b0, regs[ri]};
		end
	end
endmodule // hmr_phy_model
`default_nettype wire

// file: verif/hmr_regs_asserts.sv
// Port-level checks for the register bank.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hmr_regs_asserts
	import hmr_pkg::*;
(
	input wire logic	ref_clk,
	input wire logic	rstn,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic [7:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire hmr_mc_req_s	mc_req,
	input wire hmr_mc_res_s	mc_res,
	input wire logic	mdc
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire		ar = s_axi_arvalid && s_axi_arready;	// Read address taken.
	wire [5:0]	ai = s_axi_araddr[7:2];			// Word index asked for.
	a_res_next: assert property (mc_req.valid |=> mc_res.valid)
		else $error("filter verdict missing");
	a_res_quiet: assert property (!mc_req.valid |=> !mc_res.valid)
		else $error("filter verdict without frame");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_latency: assert property (ar |=> s_axi_rvalid)
		else $error("read answer late");
	a_b_latency: assert property (s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_unmapped_err: assert property (ar && !(ai inside {[2:7], 10}) |=> s_axi_rresp == 2'h2 && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	a_data_rsvd: assert property (ar && ai == 6'h07 |=> s_axi_rdata[31:16] == '0)
		else $error("data reserved bits set");
	a_acc_rsvd: assert property (ar && ai == 6'h06 |=> s_axi_rdata[31:16] == '0 && s_axi_rdata[5:2] == '0)
		else $error("access reserved bits set");
	a_mdc_high: assert property ($rose(mdc) |-> ##50 $fell(mdc))
		else $error("management clock high phase wrong");
	c_accept: cover property (mc_res.valid && mc_res.accept);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_frame: cover property ($rose(mdc));
endmodule // hmr_regs_asserts
bind hmr_regs hmr_regs_asserts chk_u (.ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mc_req, .mc_res, .mdc);
`default_nettype wire

// file: verif/hmr_regs_bench.sv
// Self-checking bench for the register bank, with a reference model in ex[].
// Assumes the package, design, PHY model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "hmr_defs.svh"
module hmr_regs_bench import hmr_pkg::*;;
	logic		ref_clk = 0, rstn = 0, ce = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic [7:0]	awa = '0, ara = '0;
	logic [31:0]	wd = '0, rd, got, ex [64];
	logic [3:0]	ws = 4'hF;
	logic		awr, wr, bv, arr, rv, mdc, mo, moe, mi;
	logic [1:0]	br, rr;
	logic [15:0]	d16;
	hmr_ee_wr_s	ee = '0;
	hmr_mc_req_s	mq = '0;
	hmr_mc_res_s	ms;
	int		n_fail = 0, num_checks = 0, cyc = 0, seed = 32'hA6DB;
	hmr_regs dut_u (.ref_clk, .rstn, .ce, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .ee_wr(ee), .mc_req(mq),
		.mc_res(ms), .mdc, .mdio_o(mo), .mdio_oe_n(moe), .mdio_i(mi));
	hmr_phy_model phy_u (.mdc, .mdio_o(mo), .mdio_oe_n(moe), .mdio_i(mi));
	always #2 ref_clk = ~ref_clk;
	// Three management frames dominate the run, so the ceiling sits well above them.
	always @(posedge ref_clk)
		if (++cyc == 40000)
		begin
			n_fail++;
			print_verdict;
		end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Writable bits of each word; reserved and self-clearing bits read zero.
	function automatic logic [31:0] msk(int i);
		case (i)
			2, 7: msk = 32'h0000FFFF;
			6: msk = 32'h0000FFC2;
			10: msk = 32'h00000001;
			default: msk = 32'hFFFFFFFF;
		endcase
	endfunction
	// Reference hash: CRC over the address, first wire bit first.
	function automatic logic acc(logic [47:0] da);
		logic [31:0] c;
		logic [63:0] t;
		c = 32'hFFFFFFFF;
		t = {ex[4], ex[5]};
		for (int k = 0; k < 48; k++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ da[k]) ? `HMR_CRC_POLY : 32'h0);
		acc = ex[10][0] | t[c[31:26]];
	endfunction
	// Write channel pair and response; valid holds until its own ready.
	task automatic axw(logic [5:0] i, logic [31:0] d, logic [1:0] e);
		@(posedge ref_clk);
		awa <= {i, 2'b00};
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1'($random(seed));
		forever
		begin
			@(posedge ref_clk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			if (bv && bre) break;
			bre <= 1;
		end
		bre <= 0;
		chk("bresp", 32'(br), 32'(e));
	endtask
	task automatic axr(logic [5:0] i, logic [1:0] e);
		@(posedge ref_clk);
		ara <= {i, 2'b00};
		arv <= 1;
		rre <= 1'($random(seed));
		forever
		begin
			@(posedge ref_clk);
			if (arr) arv <= 0;
			if (rv && rre) break;
			rre <= 1;
		end
		got = rd;
		rre <= 0;
		chk("rresp", 32'(rr), 32'(e));
	endtask
	task automatic ww(int i, logic [31:0] d);
		axw(6'(i), d, 2'h0);
		ex[i] = d & msk(i);
	endtask
	task automatic rc(int i);
		axr(6'(i), (i inside {[2:7], 10}) ? 2'h0 : 2'h2);
		chk("register", got, ex[i]);
	endtask
	task automatic ld(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		ee <= '{1'b1, a, d};
		@(posedge ref_clk);
		ee.valid <= 0;
	endtask
	task automatic mc(logic [47:0] da);
		@(posedge ref_clk);
		mq <= '{1'b1, da};
		@(posedge ref_clk);
		mq.valid <= 0;
		#1;
		chk("verdict", 32'({ms.valid, ms.accept}), 32'({1'b1, acc(da)}));
	endtask
	// One management transfer, with a dropped data write while busy.
	task automatic ph(logic w, logic [4:0] r, logic [15:0] v);
		ww(6, {16'h0, 5'h01, r, 4'h0, w, 1'b1});
		axr(6, 2'h0);
		chk("busy", got, ex[6] | 32'h1);
		axw(7, ~got, 2'h0);
		do axr(6, 2'h0); while (got[0] !== 1'b0);
		chk("access", got, ex[6]);
		if (!w) ex[7] = 32'(v);
		axr(7, 2'h0);
		chk("data", got, ex[7]);
	endtask
	initial
	begin
		logic [47:0] da;
		logic [7:0] b;
		logic [3:0] sb;
		foreach (ex[i]) ex[i] = '0;
		ex[2] = 32'h0000FFFF;
		ex[3] = 32'h0FFFFFFF;
		repeat (10) @(posedge ref_clk);
		rstn <= 1;
		for (int i = 0; i < 12; i++) rc(i);
		$display("test reset values done");
		for (int a = 1; a < 8; a++)
		begin
			b = 8'($random(seed));
			ld(8'(a), b);
			if (a < 5) ex[3][8*(a-1) +: 8] = b;
			else if (a < 7) ex[2][8*(a-5) +: 8] = b;
		end
		rc(2);
		rc(3);
		$display("test loader done");
		ww(2, $random(seed));
		rc(2);
		ww(3, $random(seed));
		rc(3);
		axw(9, 32'hFFFFFFFF, 2'h2);
		rc(9);
		// Clock enable low: a loader byte offered meanwhile must be lost.
		ce <= 0;
		b = 8'($random(seed));
		ld(8'h01, b);
		ce <= 1;
		rc(3);
		$display("test address write done");
		ww(4, $random(seed));
		ww(5, $random(seed));
		// Partial strobes: only the enabled byte lanes may change.
		sb = 4'($random(seed));
		ws <= sb;
		axw(6'h05, ~ex[5], 2'h0);
		ws <= 4'hF;
		for (int j = 0; j < 4; j++)
			if (sb[j]) ex[5][8*j +: 8] = ~ex[5][8*j +: 8];
		rc(5);
		for (int k = 0; k < 48; k++)
		begin
			if (k == 40) ww(10, 32'h1);
			da = 48'({$random(seed), $random(seed)});
			da[0] = 1'b1;
			mc(da);
		end
		rc(10);
		$display("test hash filter done");
		ww(7, $random(seed));
		d16 = ex[7][15:0];
		ph(1, 5'h09, 16'h0);
		ph(0, 5'h03, 16'h1003);
		ph(0, 5'h09, d16);
		$display("test phy management done");
		print_verdict;
	end
endmodule // hmr_regs_bench
`default_nettype wire
